// ==== rtl/dac_pins_map.svh ====
// constant map for the converter serial and update pin front end
`ifndef DAC_PINS_MAP_SVH
`define DAC_PINS_MAP_SVH
`define DP_WORD_BITS   32
`define DP_WORD_MSB    31
`define DP_CNT_BITS    6
`define DP_LEN_SHORT   6'h18
`define DP_LEN_LONG    6'h20
`define DP_CNT_MAX     6'h3F
`define DP_CNT_ZERO    6'h00
`define DP_CODE_BITS   16
`define DP_CODE_ZERO   16'h0000
`define DP_SPAN_BITS   3
`define DP_SPAN_0_TO_5 3'h0
`define DP_CHANNELS    8
`define DP_CHAN_BITS   3
`endif

// ==== rtl/dac_pins_pkg.sv ====
// types shared by the converter pin front end
`include "dac_pins_map.svh"
package dac_pins_pkg;
    typedef struct packed {
        logic [`DP_CODE_BITS-1:0] code;  // channel code
        logic [`DP_SPAN_BITS-1:0] span;  // output span setting
    } chan_s;

    typedef struct packed {
        logic ref_external;  // external reference mode
        logic mux_enable;    // monitor multiplexer on
    } ctrl_s;

    localparam chan_s CHAN_DEFAULT = '{code: `DP_CODE_ZERO, span: `DP_SPAN_0_TO_5};
    localparam ctrl_s CTRL_DEFAULT = '{ref_external: 1'b0, mux_enable: 1'b0};

    typedef enum logic {
        LINK_IDLE,
        LINK_SHIFT
    } link_state_e;
endpackage

// ==== rtl/pin_sync.sv ====
// two-stage pin synchroniser with edge pulses
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clk_i,     // core clock
    input  wire logic arst_n_i,  // async reset, active low
    input  wire logic pin_i,     // raw pin level
    output logic      level_o,   // synchronised level
    output logic      rise_o,    // one-cycle rising pulse
    output logic      fall_o     // one-cycle falling pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= RESET_LEVEL;
            sync_reg <= RESET_LEVEL;
            last_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges compare the settled stage with its delay
    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// ==== rtl/dac_serial_pins.sv ====
// serial port, update, clear and fault pin logic of the eight-channel converter
// Overview of operation
// - sample serial_in on sck rise while selected
// - transactions carry 24 or 32 bits
// - serial_out changes on sck falling edge
// - serial_out released while select_load_n high
// - sck ignored while select_load_n high
// - select_load_n rise stops shifting, executes word
// - update falling edge copies all channels while select_load_n high
// - select rise with update low copies all
// - clear forces zero code, 0-5 V span
// - clear restores control defaults
// - fault pulls low on error or overtemperature
// - fault released at next select rise
// - disabled monitor mux output is high impedance
// - internal reference default; external mode releases pin
// - power-up gives zero code, 0-5 V span
`timescale 1ns/10ps
`default_nettype none
`include "dac_pins_map.svh"
module dac_serial_pins
    import dac_pins_pkg::*;
#(
    parameter int CHANNELS = `DP_CHANNELS
) (
    input  wire logic                      core_clk_i,       // 125 MHz core clock
    input  wire logic                      arst_n_i,         // async reset, active low
    input  wire logic                      sck_i,            // serial clock pin
    input  wire logic                      serial_in_i,      // serial data pin
    input  wire logic                      select_load_n_i,  // select/load pin, active low
    input  wire logic                      output_update_n_i,// update pin, active low
    input  wire logic                      async_zero_n_i,   // clear pin, active low
    input  wire logic                      junction_hot_i,   // temperature above limit
    input  wire logic                      in_wr_i,          // input register write strobe
    input  wire logic [`DP_CHAN_BITS-1:0]  in_wr_chan_i,     // channel to write
    input  wire chan_s                     in_wr_data_i,     // code and span to write
    input  wire logic                      ctrl_wr_i,        // control write strobe
    input  wire ctrl_s                     ctrl_wr_data_i,   // control value
    output logic                           exec_valid_o,     // word ready pulse
    output logic [`DP_WORD_BITS-1:0]       exec_word_o,      // received word
    output logic                           exec_long_o,      // word was 32 bits
    output chan_s [CHANNELS-1:0]           dac_out_o,        // output registers
    output chan_s [CHANNELS-1:0]           input_regs_o,     // input registers
    output logic                           serial_out_o,     // serial data out
    output logic                           serial_out_oe_o,  // serial out driven
    output logic                           fault_o,          // fault pin level when driven
    output logic                           fault_oe_o,       // fault pin pulled low
    output logic                           mux_out_oe_o,     // monitor mux connected
    output logic                           ref_int_en_o      // internal reference on pin
);
    logic sck_rise, sck_fall, sdi_lvl;
    logic sel_lvl, sel_rise, sel_fall;
    logic upd_lvl, upd_fall;
    logic clr_lvl, hot_lvl;
    link_state_e                state_reg;
    logic [`DP_WORD_BITS-1:0]   shift_reg;
    logic [`DP_WORD_BITS-1:0]   out_shift_reg;
    logic [`DP_CNT_BITS-1:0]    cnt_reg;
    chan_s [CHANNELS-1:0]       in_reg;
    chan_s [CHANNELS-1:0]       dac_reg;
    ctrl_s                      ctrl_reg;
    logic                       len_ok, xfer_err, copy_all;

    // pins pass two flops before use
    pin_sync #(.RESET_LEVEL(1'b0)) u_sck (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(sck_i),
        .level_o(), .rise_o(sck_rise), .fall_o(sck_fall));
    pin_sync #(.RESET_LEVEL(1'b0)) u_sdi (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(serial_in_i),
        .level_o(sdi_lvl), .rise_o(), .fall_o());
    pin_sync #(.RESET_LEVEL(1'b1)) u_sel (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(select_load_n_i),
        .level_o(sel_lvl), .rise_o(sel_rise), .fall_o(sel_fall));
    pin_sync #(.RESET_LEVEL(1'b1)) u_upd (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(output_update_n_i),
        .level_o(upd_lvl), .rise_o(), .fall_o(upd_fall));
    pin_sync #(.RESET_LEVEL(1'b1)) u_clr (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(async_zero_n_i),
        .level_o(clr_lvl), .rise_o(), .fall_o());
    pin_sync #(.RESET_LEVEL(1'b0)) u_hot (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(junction_hot_i),
        .level_o(hot_lvl), .rise_o(), .fall_o());

    // word length check and update triggers
    assign len_ok   = (cnt_reg == `DP_LEN_SHORT) || (cnt_reg == `DP_LEN_LONG);
    assign xfer_err = sel_rise && (state_reg == LINK_SHIFT) && !len_ok;
    assign copy_all = (upd_fall && sel_lvl) || (sel_rise && !upd_lvl);

    // link state follows the select/load pin
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= LINK_IDLE;
        end else begin
            case (state_reg)
                LINK_IDLE:  if (sel_fall) state_reg <= LINK_SHIFT;
                LINK_SHIFT: if (sel_rise) state_reg <= LINK_IDLE;
                default:    state_reg <= LINK_IDLE;
            endcase
        end
    end

    // input shifter and bit counter
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_reg <= '0;
            cnt_reg   <= `DP_CNT_ZERO;
        end else if (sel_fall) begin
            cnt_reg <= `DP_CNT_ZERO;
        end else if (state_reg == LINK_SHIFT && !sel_lvl && sck_rise) begin
            shift_reg <= {shift_reg[`DP_WORD_MSB-1:0], sdi_lvl};
            if (cnt_reg != `DP_CNT_MAX) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // hand the finished word to the command logic
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            exec_valid_o <= 1'b0;
            exec_word_o  <= '0;
            exec_long_o  <= 1'b0;
        end else begin
            exec_valid_o <= sel_rise && (state_reg == LINK_SHIFT) && len_ok;
            if (sel_rise && (state_reg == LINK_SHIFT) && len_ok) begin
                exec_word_o <= shift_reg;
                exec_long_o <= (cnt_reg == `DP_LEN_LONG);
            end
        end
    end

    // output shifter echoes the previous word, msb set at select fall, later bits on sck fall
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_shift_reg   <= '0;
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            serial_out_oe_o <= !sel_lvl;
            if (sel_fall) begin
                out_shift_reg <= shift_reg;
                serial_out_o  <= shift_reg[`DP_WORD_MSB];
            end else if (state_reg == LINK_SHIFT && !sel_lvl && sck_fall) begin
                out_shift_reg <= {out_shift_reg[`DP_WORD_MSB-1:0], 1'b0};
                serial_out_o  <= out_shift_reg[`DP_WORD_MSB-1];
            end
        end
    end

    // channel registers: clear beats update and write; update copies input registers as they stood before a same-cycle write
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_reg  <= {CHANNELS{CHAN_DEFAULT}};
            dac_reg <= {CHANNELS{CHAN_DEFAULT}};
        end else if (!clr_lvl) begin
            in_reg  <= {CHANNELS{CHAN_DEFAULT}};
            dac_reg <= {CHANNELS{CHAN_DEFAULT}};
        end else begin
            if (in_wr_i) begin
                in_reg[in_wr_chan_i] <= in_wr_data_i;
            end
            if (copy_all) begin
                dac_reg <= in_reg;
            end
        end
    end
    assign dac_out_o    = dac_reg;
    assign input_regs_o = in_reg;

    // control register and the pins it steers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg     <= CTRL_DEFAULT;
            mux_out_oe_o <= 1'b0;
            ref_int_en_o <= 1'b1;
        end else begin
            if (!clr_lvl) begin
                ctrl_reg <= CTRL_DEFAULT;
            end else if (ctrl_wr_i) begin
                ctrl_reg <= ctrl_wr_data_i;
            end
            mux_out_oe_o <= ctrl_reg.mux_enable;
            ref_int_en_o <= !ctrl_reg.ref_external;
        end
    end

    // open-drain fault flag, a new cause wins over release
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_oe_o <= 1'b0;
            fault_o    <= 1'b0;
        end else if (hot_lvl || xfer_err) begin
            fault_oe_o <= 1'b1;
        end else if (sel_rise) begin
            fault_oe_o <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    bit_count_a: assert property ((state_reg == LINK_SHIFT) && !sel_lvl && sck_rise && !sel_fall
        && cnt_reg < `DP_CNT_MAX |=> cnt_reg == $past(cnt_reg) + 1'b1) else $error("bit not counted");
    exec_length_a: assert property (exec_valid_o |-> $past(cnt_reg) == `DP_LEN_SHORT
        || $past(cnt_reg) == `DP_LEN_LONG) else $error("bad length executed");
    sdo_launch_a: assert property ($changed(serial_out_o) |-> $past(sck_fall) || $past(sel_fall))
        else $error("serial out moved off a falling edge");
    sdo_release_a: assert property (sel_lvl |=> !serial_out_oe_o) else $error("serial out driven");
    idle_hold_a: assert property (sel_lvl ##1 sel_lvl |-> $stable(shift_reg))
        else $error("shifted while deselected");
    exec_word_a: assert property (sel_rise && state_reg == LINK_SHIFT && len_ok
        |=> exec_valid_o && exec_word_o == $past(shift_reg)) else $error("word not executed");
    output_update_n_copy_a: assert property (upd_fall && sel_lvl && clr_lvl |=> dac_reg == $past(in_reg))
        else $error("update edge did not copy");
    load_copy_a: assert property (sel_rise && !upd_lvl && clr_lvl |=> dac_reg == $past(in_reg))
        else $error("load with update low did not copy");
    clear_zero_a: assert property (!clr_lvl |=> dac_reg == {CHANNELS{CHAN_DEFAULT}}
        && in_reg == {CHANNELS{CHAN_DEFAULT}}) else $error("clear missed");
    clear_ctrl_a: assert property (!clr_lvl |=> ctrl_reg == CTRL_DEFAULT ##1 !mux_out_oe_o
        && ref_int_en_o) else $error("control not defaulted");
    fault_set_a: assert property (hot_lvl || xfer_err |=> fault_oe_o) else $error("fault not raised");
    fault_release_a: assert property (sel_rise && !hot_lvl && !xfer_err |=> !fault_oe_o)
        else $error("fault not released");
    mux_hiz_a: assert property (!ctrl_reg.mux_enable |=> !mux_out_oe_o) else $error("mux driven");
    ref_mode_a: assert property (ctrl_reg.ref_external |=> !ref_int_en_o)
        else $error("reference still connected");
    short_err_a: assert property (xfer_err |=> !exec_valid_o && fault_oe_o)
        else $error("bad length executed");

    exec_short_c: cover property (exec_valid_o && !exec_long_o);
    exec_long_c: cover property (exec_valid_o && exec_long_o);
    xfer_err_c: cover property (xfer_err);
    output_update_n_copy_c: cover property (upd_fall && sel_lvl);
endmodule
`default_nettype wire

// ==== bench/host_spi_model.sv ====
// host serial controller model driving the converter serial port
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
    input  wire logic core_clk_i,      // core clock for alignment
    input  wire logic serial_out_i,    // device serial data
    output logic      sck_o,           // serial clock, low outside frames except stray_clocks pulses
    output logic      serial_in_o,     // serial data to device
    output logic      select_load_n_o  // select/load, active low
);
    logic [31:0] rx_word;  // last 32 bits captured from the device
    initial begin
        sck_o = 1'b0;
        serial_in_o = 1'b0;
        select_load_n_o = 1'b1;
        rx_word = '0;
    end
    // one frame, msb first, data set while sck low, 32 ns half period
    task automatic frame(input logic [31:0] word, input int nbits);
        @(posedge core_clk_i);
        #1 select_load_n_o = 1'b0;
        #32;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in_o = word[i];
            #32 sck_o = 1'b1;
            rx_word = {rx_word[30:0], serial_out_i};
            #32 sck_o = 1'b0;
        end
        #32 select_load_n_o = 1'b1;
        serial_in_o = ~serial_in_o;  // released line shows the inverse
        #64;
    endtask
    // stray clock pulses with select high, only when the bench asks
    task automatic stray_clocks(input int n);
        repeat (n) begin
            #32 sck_o = 1'b1;
            #32 sck_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/dac_serial_pins_tb.sv ====
// self-checking bench for the converter serial and update pin logic
`timescale 1ns/10ps
`default_nettype none
module dac_serial_pins_tb;
    import dac_pins_pkg::*;
    typedef struct packed {
        logic [31:0] word;
        logic [5:0]  nbits;
        logic        good;
    } row_s;
    logic        core_clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        output_update_n = 1'b1;
    logic        async_zero_n = 1'b1;
    logic        junction_hot = 1'b0;
    logic        in_wr = 1'b0;
    logic [2:0]  in_wr_chan = 3'h0;
    chan_s       in_wr_data = CHAN_DEFAULT;
    logic        ctrl_wr = 1'b0;
    ctrl_s       ctrl_wr_data = CTRL_DEFAULT;
    logic        sck, serial_in, select_load_n, exec_valid, exec_long;
    logic        serial_out, serial_out_oe, fault, fault_oe, mux_out_oe, ref_int_en;
    logic        sdo_line;
    logic [31:0] exec_word;
    logic [31:0] prev_word = '0;
    logic        prev_long = 1'b0;
    logic        oe_seen = 1'b0;
    chan_s [7:0] dac_out, input_regs, exp_regs, held;
    int          err_total = 0;
    int          n_compared = 0;
    int          exec_cnt = 0;
    int          n0;
    row_s        rows [7] = '{'{32'hA5C3_0F17, 6'h20, 1'b1}, '{32'h1357_9BDF, 6'h20, 1'b1},
                             '{32'h005A_1E3C, 6'h18, 1'b1}, '{32'h000F_1234, 6'h14, 1'b0},
                             '{32'h8001_7FFE, 6'h20, 1'b1}, '{32'h0044_2211, 6'h17, 1'b0},
                             '{32'h00C3_3CA5, 6'h18, 1'b1}};

    always #4 core_clk_i = ~core_clk_i;
    // count exec pulses and note whether the data pin was driven
    always @(posedge core_clk_i) begin
        if (exec_valid === 1'b1) exec_cnt <= exec_cnt + 1;
        if (serial_out_oe === 1'b1) oe_seen <= 1'b1;
    end

    // an undriven data pin reads as the inverse of the last bit, so late drive shows up
    assign sdo_line = serial_out_oe ? serial_out : ~serial_out;
    host_spi_model host (.core_clk_i(core_clk_i), .serial_out_i(sdo_line), .sck_o(sck),
                         .serial_in_o(serial_in), .select_load_n_o(select_load_n));
    dac_serial_pins dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sck_i(sck),
        .serial_in_i(serial_in), .select_load_n_i(select_load_n), .output_update_n_i(output_update_n),
        .async_zero_n_i(async_zero_n), .junction_hot_i(junction_hot), .in_wr_i(in_wr),
        .in_wr_chan_i(in_wr_chan), .in_wr_data_i(in_wr_data), .ctrl_wr_i(ctrl_wr),
        .ctrl_wr_data_i(ctrl_wr_data), .exec_valid_o(exec_valid), .exec_word_o(exec_word),
        .exec_long_o(exec_long), .dac_out_o(dac_out), .input_regs_o(input_regs),
        .serial_out_o(serial_out), .serial_out_oe_o(serial_out_oe), .fault_o(fault),
        .fault_oe_o(fault_oe), .mux_out_oe_o(mux_out_oe), .ref_int_en_o(ref_int_en));

    // compare and count
    task automatic check(input logic [159:0] seen, input logic [159:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // write one input register and track it
    task automatic wr_chan(input logic [2:0] c, input chan_s d);
        @(posedge core_clk_i);
        #1 in_wr = 1'b1;
        in_wr_chan = c;
        in_wr_data = d;
        exp_regs[c] = d;
        @(posedge core_clk_i);
        #1 in_wr = 1'b0;
    endtask
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #300000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        #1 arst_n_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        exp_regs = {8{CHAN_DEFAULT}};
        check(dac_out, exp_regs, "reset outputs");
        check(input_regs, exp_regs, "reset inputs");
        check({ref_int_en, mux_out_oe, fault_oe, serial_out_oe, fault}, 5'h10, "reset pins");
        // table of frames, good and bad lengths
        foreach (rows[k]) begin
            n0 = exec_cnt;
            oe_seen = 1'b0;
            host.frame(rows[k].word, int'(rows[k].nbits));
            check(exec_cnt - n0, rows[k].good, "exec count");
            check(oe_seen, 1'b1, "data pin not driven");
            check(serial_out_oe, 1'b0, "data pin not released");
            check(fault_oe, !rows[k].good, "fault flag");
            if (rows[k].good) begin
                check(exec_long, rows[k].nbits == 6'h20, "length flag");
                check(exec_word[23:0], rows[k].word[23:0], "word");
                if (rows[k].nbits == 6'h20) check(exec_word, rows[k].word, "word");
                if (prev_long && rows[k].nbits == 6'h20) check(host.rx_word, prev_word, "echo");
                prev_word = rows[k].word;
                prev_long = rows[k].nbits == 6'h20;
            end else begin
                prev_long = 1'b0;
            end
        end
        // sck pulses with select high must not shift
        // a short frame keeps the low byte of the long one in the upper bits
        n0 = exec_cnt;
        host.frame(32'h6B2D_9E01, 32);
        host.stray_clocks(8);
        host.frame(32'h00C3_5A7E, 24);
        check(exec_cnt - n0, 2, "stray clocks counted");
        check(exec_word, 32'h01C3_5A7E, "stray clocks shifted");
        // input writes, then update pin fall copies all
        held = exp_regs;
        for (int c = 0; c < 8; c++) wr_chan(3'(c), '{code: 16'hA000 + 16'(c), span: 3'(c)});
        repeat (2) @(posedge core_clk_i);
        check(input_regs, exp_regs, "input writes");
        check(dac_out, held, "copy without update");
        #1 output_update_n = 1'b0;
        repeat (6) @(posedge core_clk_i);
        check(dac_out, exp_regs, "update fall");
        // update held low, select rise copies
        held = exp_regs;
        for (int c = 0; c < 8; c++) wr_chan(3'(c), '{code: 16'h5000 + 16'(c), span: 3'(7 - c)});
        repeat (2) @(posedge core_clk_i);
        check(dac_out, held, "copy while low");
        host.frame(32'h0000_0000, 24);
        check(dac_out, exp_regs, "select rise copy");
        @(posedge core_clk_i);
        #1 output_update_n = 1'b1;
        // overtemperature sets fault until next select rise
        @(posedge core_clk_i);
        #1 junction_hot = 1'b1;
        repeat (6) @(posedge core_clk_i);
        check({fault_oe, fault}, 2'h2, "hot fault");
        #1 junction_hot = 1'b0;
        repeat (20) @(posedge core_clk_i);
        check(fault_oe, 1'b1, "fault held");
        host.frame(32'h0012_3456, 24);
        check(fault_oe, 1'b0, "fault release");
        // control modes, then clear
        @(posedge core_clk_i);
        #1 ctrl_wr = 1'b1;
        ctrl_wr_data = '{ref_external: 1'b1, mux_enable: 1'b1};
        @(posedge core_clk_i);
        #1 ctrl_wr = 1'b0;
        repeat (3) @(posedge core_clk_i);
        check({ref_int_en, mux_out_oe}, 2'h1, "control modes");
        #1 async_zero_n = 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(dac_out, {8{CHAN_DEFAULT}}, "clear outputs");
        check(input_regs, {8{CHAN_DEFAULT}}, "clear inputs");
        check({ref_int_en, mux_out_oe}, 2'h2, "clear control");
        #1 async_zero_n = 1'b1;
        repeat (4) @(posedge core_clk_i);
        // reset in mid-run restores every default
        wr_chan(3'h5, '{code: 16'h7E81, span: 3'h4});
        @(posedge core_clk_i);
        #1 ctrl_wr = 1'b1;
        @(posedge core_clk_i);
        #1 ctrl_wr = 1'b0;
        @(posedge core_clk_i);
        #1 arst_n_i = 1'b0;
        @(posedge core_clk_i);
        #1 arst_n_i = 1'b1;
        exp_regs = {8{CHAN_DEFAULT}};
        repeat (4) @(posedge core_clk_i);
        check(input_regs, exp_regs, "mid-run reset inputs");
        check({ref_int_en, mux_out_oe, fault_oe, serial_out_oe, fault}, 5'h10, "mid-run reset pins");
        host.frame(32'h0033_CC99, 24);
        check(exec_word[23:0], 24'h33_CC99, "frame after reset");
        close_out();
    end
endmodule
`default_nettype wire
